//--- rtl/safe_pkg.sv
/*
 Package of the scanner front-end serial timing block: register map, field positions,
 reset values, timing counts and carrier types.
 Assumes a single master clock domain at 25 MHz.
*/
package safe_pkg;
	localparam logic [3:0] REG_SAMPLE_MODE = 4'h0;
	localparam logic [3:0] REG_RED_OFFSET = 4'h1;
	localparam logic [3:0] REG_LAST = 4'ha;
	localparam logic [7:0] RST_SAMPLE_MODE = 8'h62;
	localparam logic [7:0] RST_RED_OFFSET = 8'h00;
	localparam logic [7:0] RST_TEST1 = 8'h10;
	localparam logic [3:0] REG_TEST1 = 4'h9;
	localparam int BIT_DRIVER = 7;
	localparam int BIT_EDGE_SEL = 6;
	localparam int BIT_CDS_EN = 5;
	localparam int BIT_POLARITY = 4;
	localparam int BIT_CLAMP_TIMING = 3;
	localparam int BIT_REF_DELAY_HI = 2;
	localparam int BIT_REF_DELAY_LO = 1;
	localparam int BIT_POWER_DOWN = 0;
	localparam int FRAME_BITS = 13;
	localparam int OUT_BITS = 8;
	localparam int SAMPLE_WIDTH = 14;
	typedef struct packed {
		logic rd;
		logic [3:0] addr;
		logic [7:0] data;
	} safe_frame_t;
	typedef struct packed {
		logic sample_now;
		logic ref_now;
		logic ref_internal;
		logic clamp_active;
		logic clamp_to_neg;
	} safe_analog_t;
	typedef enum logic {SAFE_HI, SAFE_LO} safe_byte_t;
endpackage

//--- rtl/safe_top.sv
/*
 Serial-port register file, strobe timing and byte output of a three-channel front end.
 Assumes SCLK and SEN come from a slower external controller and are synchronised here;
 the conversion result arrives from the converter model on the master clock.
*/
// Operation
// - Input bit captured on shift-clock rise
// - Write frame stores data to register
// - Read frame returns register next enable-low
// - Output changes on falling shift edges
// - Shift while enable low; latch on rise
// - One conversion every two master clocks
// - Sample strobe samples next rising edge
// - Reference sampled one to four later
// - No CDS uses internal reference
// - Clamp plus sample ties inputs clamp
// - Result as high byte then low
// - Register zero layout, reset 62h
// - Delay field codes one to four
// - Edge select picks output edge
// - Polarity picks clamp reference
`timescale 1ns/100ps
`default_nettype none
module safe_top
	import safe_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic SCLK,
	input wire logic SEN,
	input wire logic SERIAL_IN,
	output logic SERIAL_OUT,
	input wire logic SAMPLE_STROBE,
	input wire logic CLAMP_STROBE,
	input wire logic [13:0] CONV_DATA,
	input wire logic CONV_VALID,
	output logic CONV_READY,
	input wire logic BYTE_READY,
	output logic BYTE_VALID,
	output logic [7:0] PIXEL_BYTE_OUT,
	output logic BYTE_RISE_EDGE,
	output logic SAMPLE_NOW,
	output logic REF_NOW,
	output logic REF_INTERNAL,
	output logic CLAMP_ACTIVE,
	output logic CLAMP_TO_NEG,
	output logic POWER_DOWN,
	output logic SLOW_DRIVER
);
	function automatic logic [7:0] reg_reset(input logic [3:0] a);
		if (a == REG_SAMPLE_MODE)
			return RST_SAMPLE_MODE;
		else if (a == REG_TEST1)
			return RST_TEST1;
		return RST_RED_OFFSET;
	endfunction

	// Two-flop synchronisers for the serial pins
	logic [2:0] sclk_s_q, sclk_s_d, sen_s_q, sen_s_d;
	logic [1:0] sin_s_q, sin_s_d;
	always_comb begin
		sclk_s_d = {sclk_s_q[1:0], SCLK};
		sen_s_d = {sen_s_q[1:0], SEN};
		sin_s_d = {sin_s_q[0], SERIAL_IN};
	end
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			// Idle levels of both lines, so no false edge follows reset
			sclk_s_q <= 3'h7;
			sen_s_q <= 3'h7;
			sin_s_q <= 2'h0;
		end else begin
			sclk_s_q <= sclk_s_d;
			sen_s_q <= sen_s_d;
			sin_s_q <= sin_s_d;
		end
	end

	// Edge detectors behind the second flop
	logic sclk_rise, sclk_fall, sen_rise, sen_fall, sen_lo;
	assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
	assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
	assign sen_rise = sen_s_q[1] & ~sen_s_q[2];
	assign sen_fall = ~sen_s_q[1] & sen_s_q[2];
	assign sen_lo = ~sen_s_q[1];

	// Serial shift, register file, readback
	logic [7:0] regs_q [0:10];
	logic [7:0] regs_d [0:10];
	logic [12:0] shift_q, shift_d;
	logic [3:0] rd_addr_q, rd_addr_d;
	logic [7:0] out_sr_q, out_sr_d;
	logic [3:0] out_cnt_q, out_cnt_d;
	logic so_q, so_d;
	safe_frame_t frame;
	assign frame = safe_frame_t'(shift_q);
	always_comb begin
		shift_d = shift_q;
		rd_addr_d = rd_addr_q;
		out_sr_d = out_sr_q;
		out_cnt_d = out_cnt_q;
		so_d = so_q;
		for (int i = 0; i <= 10; i++)
			regs_d[i] = regs_q[i];
		if (sen_lo && sclk_rise)
			shift_d = {shift_q[11:0], sin_s_q[1]};
		if (sen_fall) begin
			out_sr_d = regs_q[rd_addr_q];
			out_cnt_d = 4'h0;
		end
		// Falls past the eighth leave the line at its last bit
		if (sen_lo && sclk_fall && out_cnt_q < 4'(OUT_BITS)) begin
			so_d = out_sr_q[7];
			out_sr_d = {out_sr_q[6:0], 1'b0};
			out_cnt_d = out_cnt_q + 4'h1;
		end
		// Addresses past the last register are dropped; reads fall back to register 0
		if (sen_rise) begin
			rd_addr_d = (frame.addr <= REG_LAST) ? frame.addr : REG_SAMPLE_MODE;
			if (!frame.rd && frame.addr <= REG_LAST)
				regs_d[frame.addr] = frame.data;
		end
	end
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			shift_q <= 13'h0000;
			rd_addr_q <= 4'h0;
			out_sr_q <= 8'h00;
			out_cnt_q <= 4'h8;
			so_q <= 1'b0;
			for (int i = 0; i <= 10; i++)
				regs_q[i] <= reg_reset(4'(i));
		end else begin
			shift_q <= shift_d;
			rd_addr_q <= rd_addr_d;
			out_sr_q <= out_sr_d;
			out_cnt_q <= out_cnt_d;
			so_q <= so_d;
			for (int i = 0; i <= 10; i++)
				regs_q[i] <= regs_d[i];
		end
	end
	assign SERIAL_OUT = so_q;

	logic [7:0] mode;
	assign mode = regs_q[REG_SAMPLE_MODE];
	assign POWER_DOWN = mode[BIT_POWER_DOWN];
	assign SLOW_DRIVER = mode[BIT_DRIVER];
	assign BYTE_RISE_EDGE = mode[BIT_EDGE_SEL];

	// Strobe timing: sample, reference and clamp
	safe_analog_t an_q, an_d;
	logic [2:0] ref_cnt_q, ref_cnt_d;
	logic clamp_pend_q, clamp_pend_d;
	always_comb begin
		an_d = '0;
		ref_cnt_d = ref_cnt_q;
		clamp_pend_d = clamp_pend_q;
		an_d.sample_now = SAMPLE_STROBE;
		// A new strobe reloads the slot count, code 00 lands one cycle after the sample
		if (SAMPLE_STROBE) begin
			clamp_pend_d = CLAMP_STROBE;
			ref_cnt_d = 3'({1'b0, mode[BIT_REF_DELAY_HI:BIT_REF_DELAY_LO]}) + 3'h1;
		end else if (ref_cnt_q != 3'h0) begin
			ref_cnt_d = ref_cnt_q - 3'h1;
		end
		an_d.ref_now = (ref_cnt_q == 3'h1);
		an_d.ref_internal = ~mode[BIT_CDS_EN];
		an_d.clamp_active = clamp_pend_d;
		an_d.clamp_to_neg = mode[BIT_POLARITY];
	end
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			an_q <= '0;
			ref_cnt_q <= 3'h0;
			clamp_pend_q <= 1'b0;
		end else begin
			an_q <= an_d;
			ref_cnt_q <= ref_cnt_d;
			clamp_pend_q <= clamp_pend_d;
		end
	end
	assign SAMPLE_NOW = an_q.sample_now;
	assign REF_NOW = an_q.ref_now;
	assign REF_INTERNAL = an_q.ref_internal;
	assign CLAMP_ACTIVE = an_q.clamp_active;
	assign CLAMP_TO_NEG = an_q.clamp_to_neg;

	// Two-entry result buffer
	logic [13:0] buf_q [0:1];
	logic [13:0] buf_d [0:1];
	logic [1:0] cnt_q, cnt_d;
	logic wp_q, wp_d, rp_q, rp_d;
	safe_byte_t half_q, half_d;
	logic push, pop;
	assign CONV_READY = (cnt_q != 2'h2);
	assign push = CONV_VALID & CONV_READY;
	assign BYTE_VALID = (cnt_q != 2'h0);
	// One word leaves per two clocks: popped on the low byte only
	assign pop = BYTE_VALID & BYTE_READY & (half_q == SAFE_LO);
	always_comb begin
		buf_d[0] = buf_q[0];
		buf_d[1] = buf_q[1];
		wp_d = wp_q;
		rp_d = rp_q;
		half_d = half_q;
		cnt_d = cnt_q;
		if (push) begin
			buf_d[wp_q] = CONV_DATA;
			wp_d = ~wp_q;
		end
		if (BYTE_VALID && BYTE_READY) begin
			case (half_q)
				SAFE_HI: half_d = SAFE_LO;
				SAFE_LO: half_d = SAFE_HI;
				default: half_d = SAFE_HI;
			endcase
		end
		if (pop)
			rp_d = ~rp_q;
		cnt_d = cnt_q + 2'(push) - 2'(pop);
	end
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			buf_q[0] <= 14'h0000;
			buf_q[1] <= 14'h0000;
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			half_q <= SAFE_HI;
			cnt_q <= 2'h0;
		end else begin
			buf_q[0] <= buf_d[0];
			buf_q[1] <= buf_d[1];
			wp_q <= wp_d;
			rp_q <= rp_d;
			half_q <= half_d;
			cnt_q <= cnt_d;
		end
	end
	// High byte d13..d6, then d5..d0 with two low pins zero
	assign PIXEL_BYTE_OUT = (half_q == SAFE_HI) ? buf_q[rp_q][13:6] : {buf_q[rp_q][5:0], 2'b00};

	// Checks
	a_write_stores: assert property (@(posedge CLOCK) disable iff (RESET)
		sen_rise && !frame.rd && frame.addr == REG_SAMPLE_MODE |=> mode == $past(frame.data))
		else $error("write frame not stored");
	a_read_keeps: assert property (@(posedge CLOCK) disable iff (RESET)
		sen_rise && frame.rd |=> $stable(mode))
		else $error("read frame altered register");
	a_shift_gated: assert property (@(posedge CLOCK) disable iff (RESET)
		!sen_lo |=> $stable(shift_q))
		else $error("shift while enable high");
	a_out_fall_only: assert property (@(posedge CLOCK) disable iff (RESET)
		!sclk_fall |=> $stable(SERIAL_OUT))
		else $error("serial out changed off falling edge");
	a_sample_next: assert property (@(posedge CLOCK) disable iff (RESET)
		SAMPLE_STROBE |=> SAMPLE_NOW)
		else $error("sample not taken next edge");
	a_ref_delay: assert property (@(posedge CLOCK) disable iff (RESET)
		SAMPLE_STROBE && mode[2:1] == 2'b00 ##1 !SAMPLE_STROBE |=> REF_NOW)
		else $error("reference delay one wrong");
	a_clamp_level: assert property (@(posedge CLOCK) disable iff (RESET)
		SAMPLE_STROBE && CLAMP_STROBE |=> CLAMP_ACTIVE && CLAMP_TO_NEG == $past(mode[BIT_POLARITY]))
		else $error("clamp not applied");
	a_low_byte_pad: assert property (@(posedge CLOCK) disable iff (RESET)
		BYTE_VALID && half_q == SAFE_LO |-> PIXEL_BYTE_OUT[1:0] == 2'b00)
		else $error("low byte pins not zero");
	a_cds_ref: assert property (@(posedge CLOCK) disable iff (RESET)
		##1 REF_INTERNAL == !$past(mode[BIT_CDS_EN]))
		else $error("internal reference select wrong");
	a_write_red: assert property (@(posedge CLOCK) disable iff (RESET)
		sen_rise && !frame.rd && frame.addr == REG_RED_OFFSET |=> regs_q[REG_RED_OFFSET] == $past(frame.data))
		else $error("offset write not stored");
	a_addr_refused: assert property (@(posedge CLOCK) disable iff (RESET)
		sen_rise && frame.addr > REG_LAST |=> rd_addr_q == REG_SAMPLE_MODE)
		else $error("out of range address not refused");
	a_out_hold: assert property (@(posedge CLOCK) disable iff (RESET)
		sen_lo && sclk_fall && out_cnt_q == 4'(OUT_BITS) |=> $stable(SERIAL_OUT))
		else $error("serial out moved after eight bits");
	a_ref_code_one: assert property (@(posedge CLOCK) disable iff (RESET)
		SAMPLE_STROBE && mode[BIT_REF_DELAY_HI:BIT_REF_DELAY_LO] == 2'b01 ##1 !SAMPLE_STROBE [*2] |=> REF_NOW)
		else $error("reference delay two wrong");
	a_ref_code_two: assert property (@(posedge CLOCK) disable iff (RESET)
		SAMPLE_STROBE && mode[BIT_REF_DELAY_HI:BIT_REF_DELAY_LO] == 2'b10 ##1 !SAMPLE_STROBE [*3] |=> REF_NOW)
		else $error("reference delay three wrong");
	a_ref_code_three: assert property (@(posedge CLOCK) disable iff (RESET)
		SAMPLE_STROBE && mode[BIT_REF_DELAY_HI:BIT_REF_DELAY_LO] == 2'b11 ##1 !SAMPLE_STROBE [*4] |=> REF_NOW)
		else $error("reference delay four wrong");
	a_clamp_hold: assert property (@(posedge CLOCK) disable iff (RESET)
		!SAMPLE_STROBE |=> $stable(CLAMP_ACTIVE))
		else $error("clamp changed without strobe");
	a_clamp_release: assert property (@(posedge CLOCK) disable iff (RESET)
		SAMPLE_STROBE && !CLAMP_STROBE |=> !CLAMP_ACTIVE)
		else $error("clamp not released");
	a_pop_spacing: assert property (@(posedge CLOCK) disable iff (RESET)
		pop |=> !pop)
		else $error("words popped on adjacent clocks");
	a_byte_hold: assert property (@(posedge CLOCK) disable iff (RESET)
		BYTE_VALID && !BYTE_READY |=> $stable(PIXEL_BYTE_OUT))
		else $error("byte changed while stalled");
endmodule // safe_top
`default_nettype wire

//--- sim/safe_ctrl_model.sv
/*
 Scan controller model: serial frames on a 320 ns link clock, sample and clamp strobes.
 Assumes CLOCK runs at 40 ns and the block samples every pin on it.
*/
`timescale 1ns/100ps
`default_nettype none
module safe_ctrl_model (
	input wire logic CLOCK,
	input wire logic SERIAL_OUT,
	output logic SCLK,
	output logic SEN,
	output logic SERIAL_IN,
	output logic SAMPLE_STROBE,
	output logic CLAMP_STROBE
);
	initial begin
		SCLK = 1;
		SEN = 1;
		SERIAL_IN = 0;
		SAMPLE_STROBE = 0;
		CLAMP_STROBE = 0;
	end
	task automatic xfer(input logic [12:0] f, output logic [7:0] rb);
		rb = 8'h00;
		@(posedge CLOCK);
		#1 SEN = 0;
		#160;
		for (int i = 12; i >= 0; i--) begin
			SCLK = 0;
			SERIAL_IN = f[i];
			#160 SCLK = 1;
			#140 if (i > 4) rb = {rb[6:0], SERIAL_OUT};
			#20;
		end
		SEN = 1;
		// Released data line no longer shows the last bit
		SERIAL_IN = ~SERIAL_IN;
		#320;
	endtask
	task automatic strobe(input logic clamp);
		@(posedge CLOCK);
		#1 SAMPLE_STROBE = 1;
		CLAMP_STROBE = clamp;
		@(posedge CLOCK);
		#1 SAMPLE_STROBE = 0;
		CLAMP_STROBE = 0;
	endtask
endmodule // safe_ctrl_model
`default_nettype wire

//--- sim/safe_top_bench.sv
/*
 Bench of the front-end timing block: register rows, strobe slots, byte stream.
 Assumes the controller model drives the serial pins and strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module safe_top_bench;
	import safe_pkg::*;
	logic clock, reset, sclk, sen, s_in, s_out, samp, clamp_s, cvalid, cready, bready, bvalid;
	logic rise_edge, samp_now, ref_now, ref_int, clamp_act, clamp_neg, pdown, slow;
	logic [13:0] cdata;
	logic [7:0] pbo, rb;
	logic [11:0] rows [4] = '{12'h1a5, 12'ha5a, 12'h0b9, 12'h026};
	logic [7:0] bytes [4] = '{8'he9, 8'h70, 8'h34, 8'h5c};
	int num_errors = 0, n_checks = 0, s, r;
	safe_ctrl_model safe_ctrl_model_i (.CLOCK(clock), .SERIAL_OUT(s_out), .SCLK(sclk), .SEN(sen), .SERIAL_IN(s_in),
		.SAMPLE_STROBE(samp), .CLAMP_STROBE(clamp_s));
	safe_top safe_top_i (.CLOCK(clock), .RESET(reset), .SCLK(sclk), .SEN(sen), .SERIAL_IN(s_in), .SERIAL_OUT(s_out),
		.SAMPLE_STROBE(samp), .CLAMP_STROBE(clamp_s), .CONV_DATA(cdata), .CONV_VALID(cvalid), .CONV_READY(cready),
		.BYTE_READY(bready), .BYTE_VALID(bvalid), .PIXEL_BYTE_OUT(pbo), .BYTE_RISE_EDGE(rise_edge),
		.SAMPLE_NOW(samp_now), .REF_NOW(ref_now), .REF_INTERNAL(ref_int), .CLAMP_ACTIVE(clamp_act),
		.CLAMP_TO_NEG(clamp_neg), .POWER_DOWN(pdown), .SLOW_DRIVER(slow));
	initial begin
		clock = 0;
		forever #20 clock = ~clock;
	end
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic ser(input logic rw, input logic [3:0] a, input logic [7:0] d);
		safe_ctrl_model_i.xfer({rw, a, d}, rb);
	endtask
	function automatic logic [7:0] f(input logic [7:0] d);
		return {3'h0, d[7:4], d[0]};
	endfunction
	function automatic logic [7:0] lv();
		return {3'h0, slow, rise_edge, ~ref_int, clamp_neg, pdown};
	endfunction
	task automatic push(input logic [13:0] w);
		int k;
		cdata = w;
		cvalid = 1;
		for (k = 0; k < 20 && cready !== 1'b1; k++) begin
			@(posedge clock);
			#1;
		end
		if (k == 20) begin
			num_errors++;
			report_and_stop();
		end
		@(posedge clock);
		#1;
	endtask
	initial begin
		reset = 1;
		cvalid = 0;
		cdata = 14'h0000;
		bready = 0;
		repeat (20) @(posedge clock);
		#1 reset = 0;
		cmp("levels", f(8'h62), lv());
		cmp("conv_ready", 8'h01, {7'h0, cready});
		cmp("byte_valid", 8'h00, {7'h0, bvalid});
		ser(1, 4'h0, 8'hff);
		ser(1, 4'h1, 8'h00);
		cmp("reg0 reset", 8'h62, rb);
		ser(1, 4'h1, 8'h00);
		cmp("reg1 reset", 8'h00, rb);
		foreach (rows[j]) begin
			ser(0, rows[j][11:8], rows[j][7:0]);
			ser(1, rows[j][11:8], 8'hff);
			ser(1, rows[j][11:8], 8'h00);
			cmp("readback", rows[j][7:0], rb);
			if (rows[j][11:8] == 4'h0) cmp("levels", f(rows[j][7:0]), lv());
		end
		for (int c = 0; c < 4; c++) begin
			ser(0, 4'h0, {5'h04, c[1:0], 1'b0});
			safe_ctrl_model_i.strobe(1'b0);
			s = 0;
			r = 0;
			for (int k = 1; k < 10; k++) begin
				if (samp_now === 1'b1 && s == 0) s = k;
				if (ref_now === 1'b1 && r == 0) r = k;
				@(posedge clock);
				#1;
			end
			cmp("sample slot", 8'h01, s[7:0]);
			cmp("ref delay", c[7:0] + 8'h01, r[7:0] - s[7:0]);
		end
		ser(0, 4'h0, 8'h10);
		cmp("ref internal", 8'h01, {7'h0, ref_int});
		safe_ctrl_model_i.strobe(1'b1);
		#160;
		cmp("clamp", 8'h01, {7'h0, clamp_act});
		safe_ctrl_model_i.strobe(1'b0);
		#160;
		cmp("clamp", 8'h00, {7'h0, clamp_act});
		push(14'h3a5c);
		push(14'h0d17);
		cvalid = 0;
		cmp("conv_ready", 8'h00, {7'h0, cready});
		for (int j = 0; j < 4; j++) begin
			cmp("byte_valid", 8'h01, {7'h0, bvalid});
			cmp("pixel byte", bytes[j], pbo);
			bready = 1;
			@(posedge clock);
			#1 bready = 0;
			@(posedge clock);
			#1;
		end
		cmp("byte_valid", 8'h00, {7'h0, bvalid});
		// Reset in mid-run restores the power-up values
		ser(0, 4'h1, 8'h3c);
		@(posedge clock);
		#1 reset = 1;
		repeat (2) @(posedge clock);
		#1 reset = 0;
		cmp("levels", f(8'h62), lv());
		ser(1, 4'hc, 8'h00);
		ser(1, 4'h1, 8'h00);
		cmp("refused addr", 8'h62, rb);
		ser(1, 4'h1, 8'h00);
		cmp("reg1 reset", 8'h00, rb);
		report_and_stop();
	end
endmodule // safe_top_bench
`default_nettype wire
